// file: sim/lock_chk_props.sv
// port assertions for the pwm write-lock block
`timescale 1ns/1ps
module lock_chk
  import pwm_lock_pkg::*;
(
  // control
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic              write_lock_config_bit,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic              timebase_enable,
  input wire logic              period_end,
  // pwm inputs and results
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              high_side_output,
  input wire logic              low_side_output,
  input wire logic              pin_h,
  input wire logic              pin_l,
  input wire logic [DATA_W-1:0] fault_current_limit_control
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [1:0] st_q;
  logic [5:0] io_q;
  logic [3:0] ov_q;
  wire        ok = reg_wr && (st_q == 2'h2 || !write_lock_config_bit);
  wire        h_eff = ov_q[3] ? ov_q[1] : high_side_output;
  wire        l_eff = ov_q[2] ? ov_q[0] : low_side_output;
  wire        sw_h = io_q[1] ? l_eff : h_eff;
  wire        sw_l = io_q[1] ? h_eff : l_eff;
  // sequencer shadow; clk_en is held high by the bench
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      st_q <= 2'h0;
    else if (reg_wr || reg_rd)
      st_q <= (reg_wr && reg_addr == OFS_KEY && st_q != 2'h2 &&
        reg_wdata == (st_q == 2'h0 ? KEY_FIRST : KEY_SECOND)) ? st_q + 2'h1 : 2'h0;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      io_q <= 6'h00;
    else if (ok && reg_addr == OFS_IO_CTRL)
      io_q <= reg_wdata[5:0];
  // override shadow: with override_sync_select set new values wait for a running period end
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
      ov_q <= 4'h0;
    else if (!io_q[0] || (period_end && timebase_enable))
      ov_q <= io_q[5:2];
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("stray read data");
  a_status_lock: assert property (reg_rd && reg_addr == OFS_STATUS |=>
    reg_rdata[ST_LOCKEN_BIT] == $past(write_lock_config_bit)) else $error("lock bit");
  a_status_open: assert property (reg_rd && reg_addr == OFS_STATUS |=>
    reg_rdata[ST_ARMED_BIT] == (st_q == 2'h0 && $past(st_q) == 2'h2)) else $error("open bit");
  a_fcl_drop: assert property (reg_wr && reg_addr == OFS_FCL_CTRL && !ok |->
    ##2 $stable(fault_current_limit_control)) else $error("locked write taken");
  a_fcl_take: assert property (ok && reg_addr == OFS_FCL_CTRL |->
    ##2 fault_current_limit_control == $past(reg_wdata, 2)) else $error("write lost");
  a_one_write: assert property (write_lock_config_bit && reg_wr &&
    reg_addr == OFS_FCL_CTRL && $past(ok && reg_addr == OFS_FCL_CTRL) |->
    ##2 $stable(fault_current_limit_control)) else $error("second write taken");
  a_pin_high: assert property (!reset |=> pin_h == $past(sw_h))
    else $error("high pin");
  a_pin_low: assert property (!reset |=> pin_l == $past(sw_l))
    else $error("low pin");
endmodule
bind pwm_register_write_lock lock_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .write_lock_config_bit(write_lock_config_bit), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timebase_enable(timebase_enable), .period_end(period_end),
  .high_side_output(high_side_output), .low_side_output(low_side_output),
  .pin_h(pin_h), .pin_l(pin_l), .fault_current_limit_control(fault_current_limit_control));

// file: sim/tb_pwm_register_write_lock.sv
// self-checking bench for the pwm write-lock block
`timescale 1ns/1ps
module tb_pwm_register_write_lock
  import pwm_lock_pkg::*;
;
  logic        sys_clk = 0, reset = 1, lock = 1, wr = 0, rd = 0, rd_prev = 0;
  logic        ph = 0, pl = 0, pe = 0, run = 0;
  logic [3:0]  addr = '0;
  logic [15:0] wd = '0, v, rdata;
  logic [15:0] q[$];
  int          err_count = 0, checked = 0;
  always #2 sys_clk = ~sys_clk;
  pwm_register_write_lock DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
    .write_lock_config_bit(lock), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .timebase_enable(run), .period_end(pe),
    .high_side_output(ph), .low_side_output(pl), .pin_h(), .pin_l(),
    .fault_current_limit_control());
  always @(posedge sys_clk)
    {pe, pl, ph} <= 3'($urandom);
  // strobes stay up between calls so back-to-back calls give one access per cycle with no idle gap
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    q.push_back(e);
    @(posedge sys_clk);
  endtask
  // idle drops both strobes so no access repeats while waiting
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic unlock();
    wr_reg(OFS_KEY, KEY_FIRST);
    wr_reg(OFS_KEY, KEY_SECOND);
  endtask
  task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: read %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // answer is read mid-cycle, clear of the edge that updates it
  always @(negedge sys_clk)
  begin
    if (rd_prev)
      chk_rd(rdata, q.pop_front());
    rd_prev = rd;
  end
  initial
  begin
    #100000;
    err_count++;
    test_done();
  end
  initial
  begin
    void'($urandom(8035));
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rd_reg(OFS_IO_CTRL, IO_CTRL_RESET);
    rd_reg(OFS_KEY, 16'h0000);
    rd_reg(4'hf, 16'h0000);
    wr_reg(OFS_FCL_CTRL, 16'h1234);
    rd_reg(OFS_STATUS, 16'h0006);
    rd_reg(OFS_FCL_CTRL, FCL_CTRL_RESET);
    $display("locked test done");
    v = 16'($urandom);
    unlock();
    wr_reg(OFS_FCL_CTRL, v);
    wr_reg(OFS_FCL_CTRL, ~v);
    wr_reg(OFS_KEY, KEY_SECOND);
    wr_reg(OFS_KEY, KEY_FIRST);
    wr_reg(OFS_FCL_CTRL, ~v);
    wr_reg(OFS_KEY, KEY_FIRST);
    rd_reg(OFS_STATUS, 16'h0006);
    wr_reg(OFS_KEY, KEY_SECOND);
    wr_reg(OFS_FCL_CTRL, ~v);
    unlock();
    rd_reg(OFS_STATUS, 16'h0007);
    wr_reg(OFS_FCL_CTRL, ~v);
    rd_reg(OFS_FCL_CTRL, v);
    rd_reg(OFS_STATUS, 16'h0006);
    $display("sequence test done");
    repeat (4)
    begin
      run <= 1'b0;
      v = 16'($urandom);
      unlock();
      wr_reg(OFS_IO_CTRL, v);
      rd_reg(OFS_IO_CTRL, v);
      wr_reg(OFS_KEY, 16'h0000);
      run <= 1'b1;
      idle(6);
    end
    $display("swap test done");
    lock <= 1'b0;
    wr_reg(OFS_FCL_CTRL, ~v);
    rd_reg(OFS_FCL_CTRL, ~v);
    rd_reg(OFS_STATUS, 16'h0000);
    wr_reg(OFS_KEY, 16'h0000);
    idle(3);
    $display("unlocked test done");
    test_done();
  end
endmodule

// file: verilog/pin_map.sv
// output pin mapping with swap and override timing
`timescale 1ns/1ps
module pin_map
  import pwm_lock_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // control
  input  wire logic       swap,
  input  wire logic       override_sync_select,
  input  wire logic [1:0] ovr_en,
  input  wire logic [1:0] ovr_data,
  input  wire logic       period_end,
  // pwm in, pins out
  input  wire logic       pwm_h,
  input  wire logic       pwm_l,
  output logic            pin_h,
  output logic            pin_l
);
  logic [1:0] ovr_en_q;
  logic [1:0] ovr_data_q;
  logic       h_sel;
  logic       l_sel;

  // override values take effect at the period edge or at once
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ovr_en_q   <= 2'h0;
      ovr_data_q <= 2'h0;
    end
    else if (clk_en && (!override_sync_select || period_end))
    begin
      ovr_en_q   <= ovr_en;
      ovr_data_q <= ovr_data;
    end
  end

  always_comb
  begin
    h_sel = ovr_en_q[1] ? ovr_data_q[1] : pwm_h;
    l_sel = ovr_en_q[0] ? ovr_data_q[0] : pwm_l;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_h <= 1'b0;
      pin_l <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_h <= swap ? l_sel : h_sel;
      pin_l <= swap ? h_sel : l_sel;
    end
  end
endmodule

// file: verilog/pwm_lock_pkg.sv
// constants for the pwm register write-lock block
package pwm_lock_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  // register offsets
  localparam logic [3:0]  OFS_KEY         = 4'h0;
  localparam logic [3:0]  OFS_IO_CTRL     = 4'h1;
  localparam logic [3:0]  OFS_FCL_CTRL    = 4'h2;
  localparam logic [3:0]  OFS_STATUS      = 4'h3;
  // unlock keys
  localparam logic [15:0] KEY_FIRST       = 16'habcd;
  localparam logic [15:0] KEY_SECOND      = 16'h4321;
  // io control fields
  localparam int          IO_SWAP_BIT     = 1;
  localparam int          IO_OVERRIDE_SYNC_SELECT_BIT    = 0;
  localparam int          IO_OVERRIDE_OUTPUT_DATA_LO    = 2;
  localparam int          IO_OVREN_LO     = 4;
  // reset values
  localparam logic [15:0] IO_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] FCL_CTRL_RESET  = 16'h0000;
  // status fields
  localparam int          ST_ARMED_BIT    = 0;
  localparam int          ST_LOCKEN_BIT   = 1;
  localparam int          ST_REJECT_BIT   = 2;

  typedef enum logic [1:0]
  {
    LK_IDLE  = 2'b00,
    LK_KEY1  = 2'b01,
    LK_OPEN  = 2'b10
  } lock_state_t;
endpackage

// file: verilog/pwm_register_write_lock.sv
// write-lock sequencer and protected pwm control registers
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// - while locked, writes to io and fault control registers are dropped
// - lock config bit high enables locking; low makes registers freely writable
// - only key abcd followed by key 4321 counts as an unlock
// - protected write must be the very next register access after unlock
// - one unlock allows exactly one protected write
// - swap bit exchanges high and low side pins
// - override_sync_select bit defers override data to the period boundary
module pwm_register_write_lock
  import pwm_lock_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // configuration
  input  wire logic              write_lock_config_bit,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // pwm side
  input  wire logic              timebase_enable,
  input  wire logic              period_end,
  input  wire logic              high_side_output,
  input  wire logic              low_side_output,
  output logic                   pin_h,
  output logic                   pin_l,
  output logic      [DATA_W-1:0] fault_current_limit_control
);
  lock_state_t       state_q;
  lock_state_t       state_d;
  logic [DATA_W-1:0] pwm_io_control_q;
  logic [DATA_W-1:0] fcl_q;
  logic              reject_q;
  logic              access;
  logic              prot_wr;
  logic              wr_ok;

  function automatic logic is_protected(input logic [ADDR_W-1:0] a);
    is_protected = (a == OFS_IO_CTRL) || (a == OFS_FCL_CTRL);
  endfunction

  assign access  = reg_wr || reg_rd;
  assign prot_wr = reg_wr && is_protected(reg_addr);
  assign wr_ok   = prot_wr && (!write_lock_config_bit || state_q == LK_OPEN);

  // sequencer: every register access advances or resets it
  always_comb
  begin
    state_d = state_q;
    if (access)
    begin
      case (state_q)
        LK_IDLE:
        begin
          state_d = (reg_wr && reg_addr == OFS_KEY && reg_wdata == KEY_FIRST)
                    ? LK_KEY1 : LK_IDLE;
        end
        LK_KEY1:
        begin
          state_d = (reg_wr && reg_addr == OFS_KEY && reg_wdata == KEY_SECOND)
                    ? LK_OPEN : LK_IDLE;
        end
        LK_OPEN:
        begin
          // any access closes the window, the protected write included
          state_d = LK_IDLE;
        end
        default:
        begin
          state_d = LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      state_q <= LK_IDLE;
    else if (clk_en)
      state_q <= state_d;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      pwm_io_control_q <= IO_CTRL_RESET;
    else if (clk_en && wr_ok && reg_addr == OFS_IO_CTRL)
      pwm_io_control_q <= reg_wdata;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      fcl_q <= FCL_CTRL_RESET;
    else if (clk_en && wr_ok && reg_addr == OFS_FCL_CTRL)
      fcl_q <= reg_wdata;
  end

  // sticky flag of a dropped protected write, cleared by reading status
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reject_q <= 1'b0;
    else if (clk_en)
    begin
      if (prot_wr && !wr_ok)
        reject_q <= 1'b1;
      else if (reg_rd && reg_addr == OFS_STATUS)
        reject_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      reg_rdata <= '0;
      if (reg_rd)
      begin
        case (reg_addr)
          OFS_IO_CTRL:  reg_rdata <= pwm_io_control_q;
          OFS_FCL_CTRL: reg_rdata <= fcl_q;
          OFS_STATUS:
          begin
            reg_rdata[ST_ARMED_BIT]  <= (state_q == LK_OPEN);
            reg_rdata[ST_LOCKEN_BIT] <= write_lock_config_bit;
            reg_rdata[ST_REJECT_BIT] <= reject_q;
          end
          default:      reg_rdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      fault_current_limit_control <= FCL_CTRL_RESET;
    else if (clk_en)
      fault_current_limit_control <= fcl_q;
  end

  // timebase_enable only gates period_end; swap and override_sync_select stay writable while running
  pin_map u_pin_map
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clk_en     (clk_en),
    .swap       (pwm_io_control_q[IO_SWAP_BIT]),
    .override_sync_select      (pwm_io_control_q[IO_OVERRIDE_SYNC_SELECT_BIT]),
    .ovr_en     (pwm_io_control_q[IO_OVREN_LO+1:IO_OVREN_LO]),
    .ovr_data   (pwm_io_control_q[IO_OVERRIDE_OUTPUT_DATA_LO+1:IO_OVERRIDE_OUTPUT_DATA_LO]),
    .period_end (period_end && timebase_enable),
    .pwm_h      (high_side_output),
    .pwm_l      (low_side_output),
    .pin_h      (pin_h),
    .pin_l      (pin_l)
  );
endmodule
